// file: rtl/bpf_pkg.sv
package bpf_pkg;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned DEPTH       = 16;
  localparam int unsigned PTR_W       = 4;
  localparam int unsigned LVL_W       = 5;
  // Flag path stages and the in-flight cycles after the producer sees the flag.
  localparam int unsigned FLAG_STAGES = 2;
  localparam int unsigned FLIGHT_CYC  = 2;
  localparam int unsigned SLACK       = FLAG_STAGES + FLIGHT_CYC;
  localparam logic [LVL_W-1:0] AF_LVL = LVL_W'(DEPTH - SLACK);
  localparam logic [LVL_W-1:0] AE_LVL = LVL_W'(SLACK);
  localparam logic [LVL_W-1:0] LVL_ZERO = 5'h00;
  localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(DEPTH);
endpackage : bpf_pkg

// file: rtl/bpf_link_if.sv
`timescale 1ns/10ps
interface bpf_link_if;
  import bpf_pkg::*;
  logic [DATA_W-1:0] wr_data;
  logic              wr_valid;
  logic              af_delayed;
  logic              buf_full;
  logic              buf_empty;
  logic              almost_empty;
  modport buffer_end (
    input  wr_data,
    input  wr_valid,
    output af_delayed,
    output buf_full,
    output buf_empty,
    output almost_empty
  );
  modport producer_end (
    output wr_data,
    output wr_valid,
    input  af_delayed,
    input  buf_full,
    input  buf_empty,
    input  almost_empty
  );
endinterface : bpf_link_if

// file: rtl/bpf_buffer.sv
`timescale 1ns/10ps
// Behaviour
// R1 - Raw full/empty need same-cycle reaction
// R2 - Almost-full passes two register stages
// R3 - Inflow continues two cycles after flag
// R4 - Producer may send four more words
// R5 - Depth holds all in-flight words
// R6 - Word every cycle, stored when valid
// R7 - Retain words while consumer not ready
// R8 - Ready feedback stays on output hop; out_ready here also drives pop, the read pointer and the level
// R9 - Threshold equals depth minus in-flight allowance
// R10 - Almost-empty at or below threshold
module bpf_buffer (
  input  wire logic                  clock,
  input  wire logic                  reset,
  bpf_link_if.buffer_end             link,
  output logic [bpf_pkg::DATA_W-1:0] out_data,
  output logic                       out_valid,
  input  wire logic                  out_ready,
  output logic [bpf_pkg::LVL_W-1:0]  fill_level,
  output logic                       overflow_seen
);
  import bpf_pkg::*;

  // A small register array is enough at this depth and keeps the read path short.
  logic [DATA_W-1:0] mem [DEPTH];
  logic [DEPTH-1:0]  wr_sel;
  logic [PTR_W-1:0]  wr_ptr_r;
  logic [PTR_W-1:0]  wr_ptr_nxt;
  logic [PTR_W-1:0]  rd_ptr_r;
  logic [PTR_W-1:0]  rd_ptr_nxt;
  logic [LVL_W-1:0]  lvl_r;
  logic [LVL_W-1:0]  lvl_nxt;
  logic [DATA_W-1:0] out_data_r;
  logic [DATA_W-1:0] out_data_nxt;
  logic              out_valid_r;
  logic              out_valid_nxt;
  logic              af_raw;
  logic              af_s1_r;
  logic              af_s1_nxt;
  logic              af_s2_r;
  logic              af_s2_nxt;
  logic              ovf_r;
  logic              ovf_nxt;
  logic              is_full;
  logic              is_empty;
  logic              push;
  logic              pop;
  logic              drop;
  logic              load_out;

  // The level compares are made once and shared by the flags and the handshakes.
  assign is_full  = (lvl_r == LVL_FULL);
  assign is_empty = (lvl_r == LVL_ZERO);
  assign af_raw   = (lvl_r >= AF_LVL); // R9 R4

  // The consumer's ready reaches the output stage, the read pointer, the level and, through pop, the write when full. R8
  assign load_out = !out_valid_r || out_ready; // R7 R8
  assign pop      = !is_empty && load_out;
  // Valid words are stored unless the buffer is full and the consumer takes nothing. R6 R7
  assign push     = link.wr_valid && (!is_full || pop); // R5
  // A word that finds no room is lost; the slack behind the flag keeps this from happening.
  assign drop     = link.wr_valid && !push;

  // Each entry loads only when the write pointer selects it, so held words are never disturbed. R7
  for (genvar e = 0; e < DEPTH; e++) begin : g_entry
    assign wr_sel[e] = push && (wr_ptr_r == PTR_W'(e));
    always_ff @(posedge clock) begin
      if (wr_sel[e]) begin
        mem[e] <= link.wr_data; // R6
      end
    end
  end

  // The pointers wrap by themselves because the depth is a power of two.
  always_comb begin
    wr_ptr_nxt = wr_ptr_r;
    if (push) begin
      wr_ptr_nxt = wr_ptr_r + PTR_W'(1'b1);
    end
  end

  always_comb begin
    rd_ptr_nxt = rd_ptr_r;
    if (pop) begin
      rd_ptr_nxt = rd_ptr_r + PTR_W'(1'b1);
    end
  end

  // A push and a pop in one cycle leave the level where it is.
  always_comb begin
    unique case ({push, pop})
      2'b10: begin
        lvl_nxt = lvl_r + LVL_W'(1'b1);
      end
      2'b01: begin
        lvl_nxt = lvl_r - LVL_W'(1'b1);
      end
      2'b00, 2'b11: begin
        lvl_nxt = lvl_r;
      end
    endcase
  end

  // The output register refills whenever it is empty or being taken. R7
  always_comb begin
    out_valid_nxt = out_valid_r;
    out_data_nxt  = out_data_r;
    if (load_out) begin
      out_valid_nxt = pop;
    end
    if (pop) begin
      out_data_nxt = mem[rd_ptr_r];
    end
  end

  // Two stages ease routing; the lower threshold pays for them. R2 R9
  always_comb begin
    af_s1_nxt = af_raw; // R2
    af_s2_nxt = af_s1_r; // R2
  end

  // The drop flag is sticky so that a broken slack stays visible long after the event.
  always_comb begin
    ovf_nxt = ovf_r;
    if (drop) begin
      ovf_nxt = 1'b1;
    end
  end

  // One register process per concern; every reset is synchronous.
  always_ff @(posedge clock) begin
    if (reset) begin
      wr_ptr_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rd_ptr_r <= '0;
    end else begin
      rd_ptr_r <= rd_ptr_nxt;
    end
  end

  // The level counts stored words only; the word in the output register is not part of it.
  always_ff @(posedge clock) begin
    if (reset) begin
      lvl_r <= LVL_ZERO;
    end else begin
      lvl_r <= lvl_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      out_valid_r <= 1'b0;
    end else begin
      out_valid_r <= out_valid_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      out_data_r <= '0;
    end else begin
      out_data_r <= out_data_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      af_s1_r <= 1'b0;
    end else begin
      af_s1_r <= af_s1_nxt; // R2
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      af_s2_r <= 1'b0;
    end else begin
      af_s2_r <= af_s2_nxt; // R2
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ovf_r <= 1'b0;
    end else begin
      ovf_r <= ovf_nxt;
    end
  end

  // Raw full and empty are offered only to logic that can answer them in the same cycle. R1
  assign link.af_delayed   = af_s2_r; // R2
  assign link.buf_full     = is_full; // R1
  assign link.buf_empty    = is_empty; // R1
  // Almost-empty lets a reader keep pipelined reads going for as many cycles as the threshold covers.
  assign link.almost_empty = (lvl_r <= AE_LVL); // R10
  assign out_data          = out_data_r;
  assign out_valid         = out_valid_r;
  assign fill_level        = lvl_r;
  assign overflow_seen     = ovf_r;
endmodule : bpf_buffer

// file: rtl/bpf_producer.sv
`timescale 1ns/10ps
module bpf_producer (
  input  wire logic                  clock,
  input  wire logic                  reset,
  bpf_link_if.producer_end           link,
  input  wire logic [bpf_pkg::DATA_W-1:0] src_data,
  input  wire logic                  src_valid,
  output logic                       src_ready
);
  import bpf_pkg::*;

  logic [DATA_W-1:0] p1_data_r;
  logic [DATA_W-1:0] p2_data_r;
  logic              p1_valid_r;
  logic              p2_valid_r;
  logic              take;

  // The flag arrives two stages late and two words are still in the pipe. R2 R3 R4
  assign take      = src_valid && !link.af_delayed;
  assign src_ready = !link.af_delayed;

  // Two pipe stages stand for the words already sent when the flag lands. R3
  always_ff @(posedge clock) begin
    if (reset) begin
      p1_valid_r <= 1'b0;
      p2_valid_r <= 1'b0;
      p1_data_r  <= '0;
      p2_data_r  <= '0;
    end else begin
      p1_valid_r <= take;
      p1_data_r  <= src_data;
      p2_valid_r <= p1_valid_r;
      p2_data_r  <= p1_data_r;
    end
  end

  // A word goes out every cycle, tagged by its valid bit. R6
  assign link.wr_data  = p2_data_r;
  assign link.wr_valid = p2_valid_r;
endmodule : bpf_producer

// file: tb/bpf_chk.sv
`timescale 1ns/10ps
module bpf_chk (
  input wire logic clock,
  input wire logic reset,
  input wire logic wr_valid,
  input wire logic af_delayed,
  input wire logic buf_full,
  input wire logic buf_empty,
  input wire logic almost_empty
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Only the link is visible here, so the fill level is read through the flags.
  sequence s_full_hold; buf_full [*3]; endsequence
  sequence s_af_hold; af_delayed [*4]; endsequence
  property p_flag_order; !(buf_empty && buf_full); endproperty
  a_flag_order: assert property (p_flag_order) else $error("empty with full");
  property p_full_no_write; buf_full |-> !wr_valid; endproperty
  a_full_no_write: assert property (p_full_no_write) else $error("write while full");
  property p_empty_low; buf_empty |-> almost_empty; endproperty
  a_empty_low: assert property (p_empty_low) else $error("empty not low");
  property p_full_high; buf_full |-> !almost_empty; endproperty
  a_full_high: assert property (p_full_high) else $error("full but low");
  property p_af_rise; s_full_hold |-> af_delayed; endproperty
  a_af_rise: assert property (p_af_rise) else $error("late flag");
  property p_af_quiet; almost_empty |=> !af_delayed [*2]; endproperty
  a_af_quiet: assert property (p_af_quiet) else $error("early flag");
  property p_inflow_stop; s_af_hold |-> !wr_valid; endproperty
  a_inflow_stop: assert property (p_inflow_stop) else $error("inflow");
  property p_store_one; buf_empty && wr_valid |=> !buf_empty; endproperty
  a_store_one: assert property (p_store_one) else $error("lost");
  property p_hold_empty; buf_empty && !wr_valid |=> buf_empty; endproperty
  a_hold_empty: assert property (p_hold_empty) else $error("ghost");
endmodule : bpf_chk

// file: tb/backpressure_fifo_flow_ctrl_tb.sv
`timescale 1ns/10ps
module backpressure_fifo_flow_ctrl_tb;
  import bpf_pkg::*;
  logic              clock = 1'b0;
  logic              reset = 1'b1;
  logic              src_valid = 1'b0;
  logic              out_ready = 1'b0;
  logic [DATA_W-1:0] src_data = 8'h00;
  logic [DATA_W-1:0] out_data;
  logic              src_ready;
  logic              out_valid;
  logic              overflow_seen;
  logic [LVL_W-1:0]  fill_level;
  logic [DATA_W-1:0] q[$];
  int                n_errors = 0;
  int                cmp_count = 0;
  int                seed = 32'h67b9;
  int                mode = 0;
  logic [LVL_W-1:0]  lvl_h1 = '0;
  logic [LVL_W-1:0]  lvl_h2 = '0;
  bpf_link_if link ();
  bpf_buffer bpf_buffer_inst (.clock(clock), .reset(reset), .link(link), .out_data(out_data),
    .out_valid(out_valid), .out_ready(out_ready), .fill_level(fill_level), .overflow_seen(overflow_seen));
  bpf_producer bpf_producer_inst (.clock(clock), .reset(reset), .link(link), .src_data(src_data),
    .src_valid(src_valid), .src_ready(src_ready));
  bpf_chk chk_inst (.clock(clock), .reset(reset), .wr_valid(link.wr_valid), .af_delayed(link.af_delayed),
    .buf_full(link.buf_full), .buf_empty(link.buf_empty), .almost_empty(link.almost_empty));
  task automatic check(string nm, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : check
  // Almost-full reaches the producer two cycles after the level crosses depth minus the in-flight slack.
  function automatic logic exp_af(logic [LVL_W-1:0] lvl_two_ago);
    return lvl_two_ago >= LVL_W'(DEPTH - FLAG_STAGES - FLIGHT_CYC);
  endfunction : exp_af
  task automatic results;
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  initial forever #5 clock = ~clock;
  // Transfers are logged at the falling edge, where they are fixed for the next rising edge.
  always @(negedge clock) if (!reset) begin
    src_valid = (mode == 0) || (mode == 1 && $random(seed) % 2 != 0);
    out_ready = (mode == 2) || (mode == 1 && $random(seed) % 3 != 0);
    src_data = 8'($random(seed));
    if (src_valid && src_ready) q.push_back(src_data);
    if (out_valid && out_ready) check("out_data", q.pop_front(), out_data);
    check("af_delayed", 8'(exp_af(lvl_h2)), 8'(link.af_delayed));
    if (!link.af_delayed) check("src_ready", 8'h01, 8'(src_ready));
    lvl_h2 = lvl_h1;
    lvl_h1 = fill_level;
  end
  initial begin
    #40000;
    n_errors++;
    results();
  end
  initial begin
    repeat (16) @(posedge clock);
    @(negedge clock) reset <= 1'b0;
    repeat (40) @(negedge clock);
    check("fill_level", 8'(DEPTH), 8'(fill_level));
    check("stored", 8'(DEPTH + 1), 8'(q.size()));
    check("full", 8'h01, 8'(link.buf_full));
    $display("fill test done");
    mode = 1;
    repeat (2000) @(negedge clock);
    $display("random test done");
    mode = 2;
    repeat (40) @(negedge clock);
    check("backlog", 8'h00, 8'(q.size()));
    check("almost_empty", 8'h01, 8'(link.almost_empty));
    check("overflow", 8'h00, 8'(overflow_seen));
    $display("drain test done");
    results();
  end
endmodule : backpressure_fifo_flow_ctrl_tb
